// file: iew_host_model.sv
`timescale 1ns/1ps
module iew_host_model
  import iew_pkg::*;
(
  input logic sys_clk,
  input logic [7:0] regRdData_ff,
  output iew_regreq_s regReq
);
  initial regReq = '0;

  // ==========================================
  // Register port cycles
  // Released lines carry inverted values so a stale bus never looks valid
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge sys_clk);
    regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(posedge sys_clk);
    regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hFF};
    #1;
    d = regRdData_ff;
  endtask : rd_reg

  task automatic unlock();
    wr_reg(ADDR_UNLOCK_KEY, UNLOCK_VALUE);
  endtask : unlock
endmodule : iew_host_model

// file: iew_irq_wake.sv
`timescale 1ns/1ps
module iew_irq_wake
  import iew_pkg::*;
(
  input logic sys_clk,
  input logic rstn,
  input logic ce,
  input iew_regreq_s regReq,
  output logic [7:0] regRdData_ff,
  input logic [7:0] sequencerRevision,
  input iew_events_s eventFlags,
  input logic intOutputEnable,
  output logic intPinOut_ff,
  output logic intPinOeN_ff,
  input logic [7:0] channelList,
  input logic measDone,
  output logic [7:0] measReq_ff,
  output logic wakeBusy_ff,
  output logic keyUnlocked_ff
);

  // ==========================================================
  // Address decode, shared by write and read paths
  function automatic iew_sel_e decodeSel(input logic [7:0] addr, input logic legacy);
    iew_sel_e sel;
    sel = SEL_NONE;
    if (addr == ADDR_ENABLE_MASK) begin
      sel = SEL_ENABLE;
    end else if (addr == ADDR_UNLOCK_KEY) begin
      sel = SEL_KEY;
    end else if (legacy) begin
      if (addr == ADDR_LEGACY_WAKE_LOW) begin
        sel = SEL_LOW;
      end else if (addr == ADDR_LEGACY_WAKE_HIGH) begin
        sel = SEL_HIGH;
      end
    end else begin
      if (addr == ADDR_WAKE_LOW) begin
        sel = SEL_LOW;
      end else if (addr == ADDR_WAKE_HIGH) begin
        sel = SEL_HIGH;
      end
    end
    return sel;
  endfunction : decodeSel

  // ==========================================================
  // Register file
  logic [7:0] enableMask_ff, nxt_enableMask;
  logic [7:0] unlockKey_ff, nxt_unlockKey;
  logic [7:0] wakeLow_ff, nxt_wakeLow;
  logic [7:0] wakeHigh_ff, nxt_wakeHigh;
  logic [7:0] nxt_regRdData;
  logic nxt_keyUnlocked;
  logic legacyMap;
  iew_sel_e regSel;

  assign legacyMap = (sequencerRevision == LEGACY_REVISION);
  assign regSel = decodeSel(regReq.addr, legacyMap);

  always_comb begin
    nxt_enableMask = enableMask_ff;
    nxt_unlockKey = unlockKey_ff;
    nxt_wakeLow = wakeLow_ff;
    nxt_wakeHigh = wakeHigh_ff;
    nxt_regRdData = regRdData_ff;
    if (regReq.wr) begin
      case (regSel)
        SEL_ENABLE: begin
          // Reserved positions never store, so they read zero
          nxt_enableMask = regReq.data & ENABLE_WRITE_MASK;
        end
        SEL_KEY: begin
          nxt_unlockKey = regReq.data;
        end
        SEL_LOW: begin
          nxt_wakeLow = regReq.data;
        end
        SEL_HIGH: begin
          nxt_wakeHigh = regReq.data;
        end
        default: begin
        end
      endcase
    end
    if (regReq.rd) begin
      case (regSel)
        SEL_ENABLE: begin
          nxt_regRdData = enableMask_ff;
        end
        SEL_KEY: begin
          nxt_regRdData = unlockKey_ff;
        end
        SEL_LOW: begin
          nxt_regRdData = wakeLow_ff;
        end
        SEL_HIGH: begin
          nxt_regRdData = wakeHigh_ff;
        end
        default: begin
          nxt_regRdData = RESET_BYTE;
        end
      endcase
    end
    // Sequencing only runs once the host has programmed the key
    nxt_keyUnlocked = (nxt_unlockKey == UNLOCK_VALUE);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enableMask_ff <= RESET_BYTE;
      unlockKey_ff <= RESET_BYTE;
      wakeLow_ff <= RESET_BYTE;
      wakeHigh_ff <= RESET_BYTE;
      regRdData_ff <= RESET_BYTE;
      keyUnlocked_ff <= 1'b0;
    end else if (ce) begin
      enableMask_ff <= nxt_enableMask;
      unlockKey_ff <= nxt_unlockKey;
      wakeLow_ff <= nxt_wakeLow;
      wakeHigh_ff <= nxt_wakeHigh;
      regRdData_ff <= nxt_regRdData;
      keyUnlocked_ff <= nxt_keyUnlocked;
    end
  end

  // ==========================================================
  // Interrupt request and open-drain pin
  logic [4:0] srcHit;
  logic irqReq;
  logic nxt_intPinOeN;

  assign srcHit[4] = eventFlags.cmd & enableMask_ff[BIT_CMD_EN];
  assign srcHit[3] = eventFlags.prox3 & enableMask_ff[BIT_PROX3_IE];
  assign srcHit[2] = eventFlags.prox2 & enableMask_ff[BIT_PROX2_IE];
  assign srcHit[1] = eventFlags.prox1 & enableMask_ff[BIT_PROX1_IE];
  assign srcHit[0] = eventFlags.ambient & enableMask_ff[BIT_AMBIENT_IE];
  assign irqReq = |srcHit;

  always_comb begin
    // Pin is only ever pulled low, never driven high
    nxt_intPinOeN = ~(intOutputEnable & irqReq);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      intPinOut_ff <= 1'b0;
      intPinOeN_ff <= 1'b1;
    end else if (ce) begin
      intPinOut_ff <= 1'b0;
      intPinOeN_ff <= nxt_intPinOeN;
    end
  end

  // ==========================================================
  // Wake interval timer
  logic [15:0] wakeInterval;
  logic [11:0] tickCnt_ff, nxt_tickCnt;
  logic [15:0] intervalCnt_ff, nxt_intervalCnt;
  logic wakePulse_ff, nxt_wakePulse;

  assign wakeInterval = {wakeHigh_ff, wakeLow_ff};

  always_comb begin
    nxt_tickCnt = tickCnt_ff;
    nxt_intervalCnt = intervalCnt_ff;
    nxt_wakePulse = 1'b0;
    // A zero interval stops autonomous wake-ups altogether
    if (!keyUnlocked_ff || wakeInterval == 16'h0000) begin
      nxt_tickCnt = 12'h000;
      nxt_intervalCnt = 16'h0000;
    end else if (tickCnt_ff == TICK_LAST) begin
      nxt_tickCnt = 12'h000;
      // Compare with >= so a shrunk interval does not wrap the counter
      if (intervalCnt_ff + 16'h0001 >= wakeInterval) begin
        nxt_intervalCnt = 16'h0000;
        nxt_wakePulse = 1'b1;
      end else begin
        nxt_intervalCnt = intervalCnt_ff + 16'h0001;
      end
    end else begin
      nxt_tickCnt = tickCnt_ff + 12'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_ff <= 12'h000;
      intervalCnt_ff <= 16'h0000;
      wakePulse_ff <= 1'b0;
    end else if (ce) begin
      tickCnt_ff <= nxt_tickCnt;
      intervalCnt_ff <= nxt_intervalCnt;
      wakePulse_ff <= nxt_wakePulse;
    end
  end

  // ==========================================================
  // Measurement sweep over the channel list
  iew_seq_e seqState_ff, nxt_seqState;
  logic [2:0] chanIdx_ff, nxt_chanIdx;
  logic [7:0] chanList_ff, nxt_chanList;
  logic [7:0] nxt_measReq;
  logic nxt_wakeBusy;

  always_comb begin
    nxt_seqState = seqState_ff;
    nxt_chanIdx = chanIdx_ff;
    nxt_chanList = chanList_ff;
    nxt_measReq = 8'h00;
    case (seqState_ff)
      SEQ_IDLE: begin
        // A wake that lands during a sweep is dropped, not queued
        if (wakePulse_ff) begin
          nxt_chanList = channelList;
          nxt_chanIdx = 3'h0;
          nxt_seqState = SEQ_SCAN;
        end
      end
      SEQ_SCAN: begin
        if (chanList_ff[chanIdx_ff]) begin
          nxt_measReq = 8'(8'h01 << chanIdx_ff);
          nxt_seqState = SEQ_WAIT;
        end else if (chanIdx_ff == 3'h7) begin
          nxt_seqState = SEQ_IDLE;
        end else begin
          nxt_chanIdx = chanIdx_ff + 3'h1;
        end
      end
      SEQ_WAIT: begin
        if (measDone) begin
          if (chanIdx_ff == 3'h7) begin
            nxt_seqState = SEQ_IDLE;
          end else begin
            nxt_chanIdx = chanIdx_ff + 3'h1;
            nxt_seqState = SEQ_SCAN;
          end
        end
      end
      default: begin
        nxt_seqState = SEQ_IDLE;
      end
    endcase
    nxt_wakeBusy = (nxt_seqState != SEQ_IDLE);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seqState_ff <= SEQ_IDLE;
      chanIdx_ff <= 3'h0;
      chanList_ff <= 8'h00;
      measReq_ff <= 8'h00;
      wakeBusy_ff <= 1'b0;
    end else if (ce) begin
      seqState_ff <= nxt_seqState;
      chanIdx_ff <= nxt_chanIdx;
      chanList_ff <= nxt_chanList;
      measReq_ff <= nxt_measReq;
      wakeBusy_ff <= nxt_wakeBusy;
    end
  end

  // ==========================================================
  // Checks
  logic [31:0] gapCnt_ff;
  logic gapValid_ff;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gapCnt_ff <= 32'h0;
      gapValid_ff <= 1'b0;
    end else if (ce) begin
      if (wakePulse_ff) begin
        gapCnt_ff <= 32'h0;
        gapValid_ff <= 1'b1;
      end else begin
        gapCnt_ff <= gapCnt_ff + 32'h1;
      end
      if (regReq.wr && (regSel == SEL_LOW || regSel == SEL_HIGH || regSel == SEL_KEY)) begin
        gapValid_ff <= 1'b0;
      end
    end
  end

  cmd_irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ce && intOutputEnable && eventFlags == 5'h10) |=> (intPinOeN_ff == !$past(enableMask_ff[BIT_CMD_EN])))
    else $error("command event gating wrong");

  prox3_irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ce && intOutputEnable && eventFlags == 5'h08) |=> (intPinOeN_ff == !$past(enableMask_ff[BIT_PROX3_IE])))
    else $error("prox channel three gating wrong");

  prox2_irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ce && intOutputEnable && eventFlags == 5'h04) |=> (intPinOeN_ff == !$past(enableMask_ff[BIT_PROX2_IE])))
    else $error("prox channel two gating wrong");

  prox1_irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ce && intOutputEnable && eventFlags == 5'h02) |=> (intPinOeN_ff == !$past(enableMask_ff[BIT_PROX1_IE])))
    else $error("prox channel one gating wrong");

  ambient_irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ce && intOutputEnable && eventFlags == 5'h01) |=> (intPinOeN_ff == !$past(enableMask_ff[BIT_AMBIENT_IE])))
    else $error("ambient event gating wrong");

  reset_values_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(rstn) |-> (enableMask_ff == 8'h00 && unlockKey_ff == 8'h00 && wakeLow_ff == 8'h00))
    else $error("register not zero after reset");

  wake_spacing_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wakePulse_ff && gapValid_ff && $stable(wakeInterval) && ce && $past(ce))
      |-> (gapCnt_ff == 32'(wakeInterval) * 32'(TICK_CYCLES) - 32'h1))
    else $error("wake spacing differs from interval");

  sweep_selected_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (measReq_ff != 8'h00) |-> ((measReq_ff & ~chanList_ff) == 8'h00 && $onehot(measReq_ff)))
    else $error("request for unselected channel");

  sweep_start_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ce && wakePulse_ff && seqState_ff == SEQ_IDLE && channelList[0]) |=> ce [*2] ##0 (measReq_ff == 8'h01))
    else $error("first selected channel not measured");

  legacy_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ce && regReq.wr && legacyMap && regReq.addr == ADDR_LEGACY_WAKE_LOW) |=> (wakeLow_ff == $past(regReq.data)))
    else $error("legacy low byte offset not honoured");

  pin_disabled_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ce && !intOutputEnable) |=> (intPinOeN_ff && !intPinOut_ff))
    else $error("pin driven while output disabled");

  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ce && intOutputEnable && (eventFlags & {enableMask_ff[5], enableMask_ff[4:2], enableMask_ff[0]}) == 5'h00)
      |=> intPinOeN_ff && enableMask_ff[7:6] == 2'h0 && !enableMask_ff[1])
    else $error("interrupt without enabled flag");

endmodule : iew_irq_wake

// file: iew_pkg.sv
package iew_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_ENABLE_MASK = 8'h04;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h07;
  localparam logic [7:0] ADDR_WAKE_LOW = 8'h08;
  localparam logic [7:0] ADDR_WAKE_HIGH = 8'h09;
  localparam logic [7:0] ADDR_LEGACY_WAKE_LOW = 8'h0A;
  localparam logic [7:0] ADDR_LEGACY_WAKE_HIGH = 8'h08;

  // ==========================================================
  // Fields and reset values
  localparam int BIT_CMD_EN = 5;
  localparam int BIT_PROX3_IE = 4;
  localparam int BIT_PROX2_IE = 3;
  localparam int BIT_PROX1_IE = 2;
  localparam int BIT_AMBIENT_IE = 0;
  localparam logic [7:0] ENABLE_WRITE_MASK = 8'h3D;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] UNLOCK_VALUE = 8'h17;
  // Arbitrary neutral value standing for the revision with the interval low byte at 0x0A and high byte at 0x08
  localparam logic [7:0] LEGACY_REVISION = 8'h5A;

  // ==========================================================
  // Timing
  localparam real TICK_US = 31.25;
  localparam real CLK_PERIOD_NS = 10.0;
  localparam int TICK_CYCLES = int'(TICK_US * 1000.0 / CLK_PERIOD_NS);
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SCAN = 2'b01,
    SEQ_WAIT = 2'b10
  } iew_seq_e;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_ENABLE = 3'b001,
    SEL_KEY = 3'b010,
    SEL_LOW = 3'b011,
    SEL_HIGH = 3'b100
  } iew_sel_e;

  typedef struct packed {
    logic cmd;
    logic prox3;
    logic prox2;
    logic prox1;
    logic ambient;
  } iew_events_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } iew_regreq_s;

endpackage : iew_pkg

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import iew_pkg::*;
  logic sys_clk;
  logic rstn;
  logic ce;
  iew_regreq_s regReq;
  logic [7:0] regRdData_ff;
  logic [7:0] sequencerRevision;
  iew_events_s eventFlags;
  logic intOutputEnable;
  logic intPinOut_ff;
  logic intPinOeN_ff;
  logic [7:0] channelList;
  logic measDone;
  logic [7:0] measReq_ff;
  logic wakeBusy_ff;
  logic keyUnlocked_ff;
  int errCount = 0;
  int totalChecks = 0;
  int cyc = 0;

  iew_irq_wake uut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .regReq(regReq),
    .regRdData_ff(regRdData_ff), .sequencerRevision(sequencerRevision),
    .eventFlags(eventFlags), .intOutputEnable(intOutputEnable),
    .intPinOut_ff(intPinOut_ff), .intPinOeN_ff(intPinOeN_ff),
    .channelList(channelList), .measDone(measDone), .measReq_ff(measReq_ff),
    .wakeBusy_ff(wakeBusy_ff), .keyUnlocked_ff(keyUnlocked_ff));

  iew_host_model host (.sys_clk(sys_clk), .regRdData_ff(regRdData_ff), .regReq(regReq));

  // ==========================================
  // Checking helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chkNum(input string what, input int exp, input int got);
    totalChecks++;
    if (got != exp) begin
      errCount++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chkNum

  task automatic stopTest();
    if (errCount == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stopTest

  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : ticks

  // Bounded wait for a channel request, then answer it promptly
  task automatic waitReq(input logic [7:0] exp, output int at);
    int n;
    n = 0;
    while (measReq_ff === 8'h00 && n < 4000) begin
      ticks(1);
      n++;
    end
    at = cyc;
    chk("request", exp, measReq_ff);
    if (n >= 4000) stopTest();
    @(posedge sys_clk);
    measDone <= 1'b1;
    @(posedge sys_clk);
    measDone <= 1'b0;
    // Step off the edge so callers see settled outputs
    #1;
  endtask : waitReq

  // ==========================================
  // Scenarios
  task automatic resetValues();
    logic [7:0] d;
    host.rd_reg(ADDR_ENABLE_MASK, d);
    chk("enable", RESET_BYTE, d);
    chk("locked", 8'h00, {7'h00, keyUnlocked_ff});
    host.rd_reg(ADDR_UNLOCK_KEY, d);
    chk("key", RESET_BYTE, d);
    host.rd_reg(ADDR_WAKE_LOW, d);
    chk("low", RESET_BYTE, d);
    chk("pin idle", 8'h01, {7'h00, intPinOeN_ff});
  endtask : resetValues

  task automatic maskBits();
    logic [7:0] d;
    host.wr_reg(ADDR_ENABLE_MASK, 8'hFF);
    host.rd_reg(ADDR_ENABLE_MASK, d);
    chk("mask", ENABLE_WRITE_MASK, d);
    host.rd_reg(8'h0B, d);
    chk("unmapped", 8'h00, d);
  endtask : maskBits

  task automatic srcGate();
    int en [5] = '{BIT_AMBIENT_IE, BIT_PROX1_IE, BIT_PROX2_IE, BIT_PROX3_IE, BIT_CMD_EN};
    for (int i = 0; i < 5; i++) begin
      host.wr_reg(ADDR_ENABLE_MASK, 8'(1 << en[i]));
      @(posedge sys_clk);
      intOutputEnable <= 1'b1;
      eventFlags <= iew_events_s'(5'(1 << i));
      ticks(2);
      chk("pin on", 8'h00, {7'h00, intPinOeN_ff});
      chk("pin data", 8'h00, {7'h00, intPinOut_ff});
      @(posedge sys_clk);
      intOutputEnable <= 1'b0;
      ticks(2);
      chk("pin oe off", 8'h01, {7'h00, intPinOeN_ff});
      @(posedge sys_clk);
      intOutputEnable <= 1'b1;
      eventFlags <= iew_events_s'(~5'(1 << i));
      ticks(2);
      chk("pin masked", 8'h01, {7'h00, intPinOeN_ff});
      @(posedge sys_clk);
      eventFlags <= iew_events_s'(5'(1 << i));
      // Every other source enabled, only this one off
      host.wr_reg(ADDR_ENABLE_MASK, ENABLE_WRITE_MASK & ~8'(1 << en[i]));
      ticks(2);
      chk("pin own bit off", 8'h01, {7'h00, intPinOeN_ff});
      @(posedge sys_clk);
      eventFlags <= '0;
    end
  endtask : srcGate

  task automatic wakeSweep();
    int t0;
    int t1;
    @(posedge sys_clk);
    channelList <= 8'h05;
    host.unlock();
    ticks(1);
    chk("unlocked", 8'h01, {7'h00, keyUnlocked_ff});
    host.wr_reg(ADDR_WAKE_LOW, 8'h01);
    waitReq(8'h01, t0);
    chk("busy", 8'h01, {7'h00, wakeBusy_ff});
    waitReq(8'h04, t1);
    ticks(20);
    chk("idle", 8'h00, {7'h00, wakeBusy_ff});
    waitReq(8'h01, t1);
    chkNum("spacing", TICK_CYCLES, t1 - t0);
    waitReq(8'h04, t0);
    host.wr_reg(ADDR_WAKE_LOW, 8'h00);
  endtask : wakeSweep

  task automatic legacyMap();
    logic [7:0] d;
    @(posedge sys_clk);
    sequencerRevision <= LEGACY_REVISION;
    host.wr_reg(ADDR_LEGACY_WAKE_LOW, 8'hA5);
    host.wr_reg(ADDR_LEGACY_WAKE_HIGH, 8'h3C);
    host.rd_reg(ADDR_WAKE_HIGH, d);
    chk("legacy 0x09", 8'h00, d);
    @(posedge sys_clk);
    sequencerRevision <= 8'h00;
    host.rd_reg(ADDR_WAKE_LOW, d);
    chk("low via 0x0A", 8'hA5, d);
    host.rd_reg(ADDR_WAKE_HIGH, d);
    chk("high via 0x08", 8'h3C, d);
  endtask : legacyMap

  // A write while the clock enable is low must leave the mask untouched
  task automatic ceFreeze();
    logic [7:0] d;
    @(posedge sys_clk);
    ce <= 1'b0;
    host.wr_reg(ADDR_ENABLE_MASK, 8'h01);
    @(posedge sys_clk);
    ce <= 1'b1;
    host.rd_reg(ADDR_ENABLE_MASK, d);
    chk("frozen mask", ENABLE_WRITE_MASK & ~8'(1 << BIT_CMD_EN), d);
  endtask : ceFreeze

  // ==========================================
  // Clock and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    sequencerRevision = 8'h00;
    eventFlags = '0;
    intOutputEnable = 1'b0;
    channelList = 8'h00;
    measDone = 1'b0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    resetValues();
    maskBits();
    srcGate();
    wakeSweep();
    legacyMap();
    ceFreeze();
    stopTest();
  end
endmodule : testbench
